// file: core/stl_stall_detector.sv
// stall detector top: register bus, coil bridge gates, sense routing, counter, accumulator
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "stl_defs.svh"
// register map, byte address four times the index
// 0 return_zero_control: 7 integrate, 6 drive, 5 low-side recirculation, 4 polarity,
//   2 motor select, 1:0 step
// 1 down_counter_control: 7 run, 1:0 prescale, a power of four
// 2 detector_control: 7 return_zero_enable, 1 saturate mask, 0 counter mask
// 3 detector_flags: 5:4 mode, 1 saturated, 0 counter zero; a read clears 1:0
// 4, 5 counter modulus high and low; a write reloads, a read gives the live count
// 6, 7 accumulator high and low, read only
module stl_stall_detector #(
  parameter int CNT_WIDTH = 16,
  parameter int ACC_WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sdBit,
  output logic [7:0] bridgeGatesA,
  output logic [7:0] bridgeGatesB,
  output stl_pkg::stl_sense_t sense,
  output logic irq
);
  // control registers
  stl_pkg::stl_rtz_ctl_t return_zero_control_q;
  logic [7:0] cntCtl_q;
  logic [7:0] detCtl_q;
  logic [1:0] flags_q;
  logic [1:0] flags_d;

  // bus state
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // pin-side state
  logic [7:0] gatesA_q;
  logic [7:0] gatesB_q;
  stl_pkg::stl_sense_t sense_q;
  logic irq_q;

  // write decode
  logic wrFire;
  logic wrMapped;
  logic wrLane;
  logic [2:0] wrIdx;
  logic [7:0] wrByte;
  logic wrRtz;
  logic wrCnt;
  logic wrDet;
  logic wrCntHi;
  logic wrCntLo;

  // read decode
  logic rdFire;
  logic rdMapped;
  logic [2:0] rdIdx;
  logic [7:0] rdByte;
  logic rdFlags;

  // block datapath
  logic [CNT_WIDTH-1:0] count;
  logic counterZero;
  logic [ACC_WIDTH-1:0] accSum;
  logic accSaturate;
  logic rtzEnable;
  stl_pkg::stl_mode_t mode;
  logic [1:0] events;
  logic [7:0] gates;

  assign wrFire = awready_q && s_axi_awvalid && s_axi_wvalid;
  assign wrMapped = s_axi_awaddr < `STL_REG_SPAN;
  assign wrLane = s_axi_wstrb[0];
  assign wrIdx = s_axi_awaddr[4:2];
  assign wrByte = s_axi_wdata[7:0];
  assign wrRtz = wrFire && wrMapped && wrLane && (wrIdx == `STL_IDX_RTZ_CTL);
  assign wrCnt = wrFire && wrMapped && wrLane && (wrIdx == `STL_IDX_CNT_CTL);
  assign wrDet = wrFire && wrMapped && wrLane && (wrIdx == `STL_IDX_DET_CTL);
  assign wrCntHi = wrFire && wrMapped && wrLane && (wrIdx == `STL_IDX_CNT_HI);
  assign wrCntLo = wrFire && wrMapped && wrLane && (wrIdx == `STL_IDX_CNT_LO);

  assign rdFire = arready_q && s_axi_arvalid;
  assign rdMapped = s_axi_araddr < `STL_REG_SPAN;
  assign rdIdx = s_axi_araddr[4:2];
  assign rdFlags = rdFire && rdMapped && (rdIdx == `STL_IDX_DET_FLG);

  assign rtzEnable = detCtl_q[`STL_DET_RTZ_ENABLE];
  // mode from the integrate and drive bits
  assign mode = stl_pkg::stl_mode_t'({return_zero_control_q.integrateEnable,
                                      return_zero_control_q.driveCoilEnable});
  assign events = {accSaturate, counterZero};
  // sticky flags: a new event wins over the clear by read
  assign flags_d = (rdFlags ? 2'h0 : flags_q) | events;

  // accumulator bytes read only; writes to 6 and 7 are dropped
  // flags are read before the clear of the same edge takes effect
  always_comb begin
    case (rdIdx)
      `STL_IDX_RTZ_CTL: rdByte = return_zero_control_q;
      `STL_IDX_CNT_CTL: rdByte = cntCtl_q;
      `STL_IDX_DET_CTL: rdByte = detCtl_q;
      `STL_IDX_DET_FLG: rdByte = {2'h0, mode, 2'h0, flags_q};
      `STL_IDX_CNT_HI: rdByte = count[CNT_WIDTH-1:8];
      `STL_IDX_CNT_LO: rdByte = count[7:0];
      `STL_IDX_ACC_HI: rdByte = accSum[ACC_WIDTH-1:8];
      `STL_IDX_ACC_LO: rdByte = accSum[7:0];
      default: rdByte = 8'h00;
    endcase
  end

  // bridge gates T1..T8 in bits 0..7: T1/T4 and T2/T3 cosine, T5/T8 and T6/T7 sine
  always_comb begin
    gates = 8'h00;
    if (rtzEnable) begin
      if (return_zero_control_q.driveCoilEnable) begin
        case (return_zero_control_q.step)
          2'b00: gates = gates | 8'h09;
          2'b01: gates = gates | 8'h90;
          2'b10: gates = gates | 8'h06;
          2'b11: gates = gates | 8'h60;
          default: gates = 8'h00;
        endcase
      end
      // blanking recirculates the non-driven coil; integration leaves it floating
      if (!return_zero_control_q.integrateEnable) begin
        case ({return_zero_control_q.step[0], return_zero_control_q.recircLowSide})
          2'b00: gates = gates | 8'h50;
          2'b01: gates = gates | 8'hA0;
          2'b10: gates = gates | 8'h05;
          2'b11: gates = gates | 8'h0A;
          default: gates = 8'h00;
        endcase
      end
    end
  end

  // counter and accumulator keep their own state; the top only routes bytes
  stl_down_counter #(
    .WIDTH(CNT_WIDTH)
  ) u_counter (
    .mclk(mclk),
    .rst(rst),
    .run(cntCtl_q[`STL_CNT_RUN]),
    .preSel(cntCtl_q[`STL_CNT_PRE_HI:`STL_CNT_PRE_LO]),
    .wrHigh(wrCntHi),
    .wrLow(wrCntLo),
    .wrByte(wrByte),
    .count(count),
    .zeroPulse(counterZero)
  );

  stl_integrator #(
    .WIDTH(ACC_WIDTH)
  ) u_integrator (
    .mclk(mclk),
    .rst(rst),
    .enable(return_zero_control_q.integrateEnable),
    .polarity(return_zero_control_q.integrationPolarity),
    .sdBit(sdBit),
    .sum(accSum),
    .saturatePulse(accSaturate)
  );

  // control register writes
  // only byte lane 0 carries register data
  always_ff @(posedge mclk) begin
    if (rst) begin
      return_zero_control_q <= `STL_RST_CTL;
      cntCtl_q <= `STL_RST_CTL;
      detCtl_q <= `STL_RST_CTL;
    end else begin
      if (wrRtz) begin
        return_zero_control_q <= wrByte;
      end
      if (wrCnt) begin
        cntCtl_q <= wrByte;
      end
      if (wrDet) begin
        detCtl_q <= wrByte;
      end
    end
  end

  // status flags and interrupt
  // irq follows the flags in the same cycle, so a mask change acts one cycle late
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_q <= |(flags_d & detCtl_q[1:0]);
    end
  end

  // only the selected motor sees its gates; the other bridge stays off
  // gates and sense lag control writes by one cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      gatesA_q <= 8'h00;
      gatesB_q <= 8'h00;
      sense_q <= '0;
    end else begin
      gatesA_q <= return_zero_control_q.motorSelect ? 8'h00 : gates;
      gatesB_q <= return_zero_control_q.motorSelect ? gates : 8'h00;
      sense_q.motorSelect <= return_zero_control_q.motorSelect;
      sense_q.senseSine <= ~return_zero_control_q.step[0];
      sense_q.polarity <= return_zero_control_q.integrationPolarity;
      sense_q.converterReset <= ~return_zero_control_q.integrateEnable;
    end
  end

  // write channel: address and data taken together
  // ready pulses once both valids stand and no answer is pending
  always_ff @(posedge mclk) begin
    if (rst) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `STL_RESP_OKAY;
    end else begin
      awready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
      wready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
      if (wrFire) begin
        bvalid_q <= 1'b1;
        bresp_q <= !wrMapped ? `STL_RESP_DECERR : `STL_RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel
  // rvalid stands until rready; no new address is taken meanwhile
  always_ff @(posedge mclk) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `STL_RESP_OKAY;
    end else begin
      arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
      if (rdFire) begin
        rvalid_q <= 1'b1;
        rdata_q <= rdMapped ? {24'h00_0000, rdByte} : 32'h0000_0000;
        rresp_q <= rdMapped ? `STL_RESP_OKAY : `STL_RESP_DECERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign bridgeGatesA = gatesA_q;
  assign bridgeGatesB = gatesB_q;
  assign sense = sense_q;
  assign irq = irq_q;
endmodule

// file: include/stl_defs.svh
// register indices, field positions, reset values and divider settings of the stall detector
`ifndef STL_DEFS_SVH
`define STL_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define STL_IDX_RTZ_CTL 3'h0
`define STL_IDX_CNT_CTL 3'h1
`define STL_IDX_DET_CTL 3'h2
`define STL_IDX_DET_FLG 3'h3
`define STL_IDX_CNT_HI 3'h4
`define STL_IDX_CNT_LO 3'h5
`define STL_IDX_ACC_HI 3'h6
`define STL_IDX_ACC_LO 3'h7

// return_zero_control fields
`define STL_RTZ_INTEGRATE 7
`define STL_RTZ_DRIVE 6
`define STL_RTZ_RECIRC 5
`define STL_RTZ_POLARITY 4
`define STL_RTZ_MOTOR 2
`define STL_RTZ_STEP_HI 1
`define STL_RTZ_STEP_LO 0

// down_counter_control fields
`define STL_CNT_RUN 7
`define STL_CNT_PRE_HI 1
`define STL_CNT_PRE_LO 0

// detector_control: enable and interrupt masks; detector_flags: same low bits
`define STL_DET_RTZ_ENABLE 7
`define STL_EVT_COUNTER 0
`define STL_EVT_SATURATE 1
`define STL_FLG_MODE_HI 5
`define STL_FLG_MODE_LO 4

// reset values
`define STL_RST_CTL 8'h00
`define STL_RST_COUNT 16'h0000

// prescaler: divide by 4 to the power of the select field
`define STL_PRE_SHIFT 2
`define STL_PRE_WIDTH 6

// bus answers
`define STL_RESP_OKAY 2'h0
`define STL_RESP_SLVERR 2'h2
`define STL_RESP_DECERR 2'h3
`define STL_REG_SPAN 32'h0000_0020

`endif

// file: include/stl_pkg.sv
// types shared by the stall detector files
package stl_pkg;

  typedef enum logic [1:0] {
    STL_BLANK_NO_DRIVE = 2'b00,
    STL_BLANK_DRIVE = 2'b01,
    STL_CONVERSION = 2'b10,
    STL_INTEGRATION = 2'b11
  } stl_mode_t;

  typedef struct packed {
    logic integrateEnable;
    logic driveCoilEnable;
    logic recircLowSide;
    logic integrationPolarity;
    logic spare;
    logic motorSelect;
    logic [1:0] step;
  } stl_rtz_ctl_t;

  typedef struct packed {
    logic motorSelect;
    logic senseSine;
    logic polarity;
    logic converterReset;
  } stl_sense_t;

endpackage

// file: core/stl_down_counter.sv
// prescaled 16-bit modulus down counter with reload
`timescale 1ns/10ps
`include "stl_defs.svh"
module stl_down_counter #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] preSel,
  input wire logic wrHigh,
  input wire logic wrLow,
  input wire logic [7:0] wrByte,
  output logic [WIDTH-1:0] count,
  output logic zeroPulse
);
  logic [`STL_PRE_WIDTH-1:0] pre_q;
  logic [WIDTH-1:0] modulus_q;
  logic [WIDTH-1:0] count_q;
  logic zero_q;
  logic [`STL_PRE_WIDTH-1:0] preMask;
  logic tick;
  logic [WIDTH-1:0] newModulus;

  assign preMask = `STL_PRE_WIDTH'((1 << (`STL_PRE_SHIFT * preSel)) - 1);
  assign tick = run && ((pre_q & preMask) == preMask);
  assign newModulus = wrHigh ? {wrByte, modulus_q[7:0]} :
                      wrLow ? {modulus_q[WIDTH-1:8], wrByte} : modulus_q;
  assign count = count_q;
  assign zeroPulse = zero_q;

  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // a write reloads the count; otherwise count down, reload on the tick after reaching zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      modulus_q <= `STL_RST_COUNT;
      count_q <= `STL_RST_COUNT;
      zero_q <= 1'b0;
    end else if (wrHigh || wrLow) begin
      modulus_q <= newModulus;
      count_q <= newModulus;
      zero_q <= 1'b0;
    end else begin
      zero_q <= tick && (count_q == WIDTH'(1));
      if (tick) begin
        count_q <= (count_q == '0) ? modulus_q : count_q - 1'b1;
      end
    end
  end
endmodule

// file: core/stl_integrator.sv
// back-emf accumulator fed by the sigma-delta bit stream
`timescale 1ns/10ps
module stl_integrator #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic polarity,
  input wire logic sdBit,
  output logic [WIDTH-1:0] sum,
  output logic saturatePulse
);
  localparam logic signed [WIDTH-1:0] MAXV = {1'b0, {(WIDTH-1){1'b1}}};
  localparam logic signed [WIDTH-1:0] MINV = {1'b1, {(WIDTH-1){1'b0}}};
  logic signed [WIDTH-1:0] sum_q;
  logic sat_q;
  logic up;
  logic atLimit;

  // polarity swaps which coil end feeds the converter
  assign up = sdBit ^ polarity;
  assign atLimit = up ? (sum_q == MAXV) : (sum_q == MINV);
  assign sum = sum_q;
  assign saturatePulse = sat_q;

  always_ff @(posedge mclk) begin
    if (rst || !enable) begin
      sum_q <= '0;
      sat_q <= 1'b0;
    end else begin
      sat_q <= atLimit;
      if (!atLimit) begin
        sum_q <= up ? sum_q + 1'b1 : sum_q - 1'b1;
      end
    end
  end
endmodule

// file: bench/stl_stall_detector_chk.sv
// bus handshake and bridge gate checks for the stall detector
`timescale 1ns/10ps
module stl_stall_detector_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] bridgeGatesA,
  input wire logic [7:0] bridgeGatesB
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  wr_take_a: assert property (s_axi_awready |->
    s_axi_awvalid && s_axi_wvalid && s_axi_wready)
    else $error("write taken without both channels");
  wr_resp_a: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write answer late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (!(s_axi_arvalid && s_axi_arready) |=>
    $stable(s_axi_rdata))
    else $error("read data changed without a read");
  rd_decerr_a: assert property (s_axi_arready && s_axi_araddr >= 32'h20 |=>
    s_axi_rresp == 2'h3)
    else $error("unmapped read not refused");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper bits set");
  gate_short_a: assert property (((bridgeGatesA & (bridgeGatesA << 1) & 8'hAA) |
    (bridgeGatesB & (bridgeGatesB << 1) & 8'hAA)) == 0)
    else $error("half bridge shorted");
  one_motor_a: assert property (!(|bridgeGatesA && |bridgeGatesB))
    else $error("both motors driven");
endmodule
bind stl_stall_detector stl_stall_detector_chk chk (.mclk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bridgeGatesA, .bridgeGatesB);

// file: bench/stl_motor_model.sv
// back-emf source standing in for the coils of the two motors
`timescale 1ns/10ps
module stl_motor_model (
  input wire logic mclk,
  input wire logic [7:0] gatesA,
  input wire logic [7:0] gatesB,
  input wire stl_pkg::stl_sense_t sense,
  input wire logic stalled,
  output logic sdBit
);
  logic flip_q = 1'b0;
  logic moving;
  // only a driven, turning rotor gives steady emf; otherwise noise
  assign moving = !stalled && |(sense.motorSelect ? gatesB : gatesA);
  always_ff @(posedge mclk) flip_q <= ~flip_q;
  assign sdBit = moving ? 1'b1 : flip_q;
endmodule

// file: bench/tb.sv
// self-checking bench for the stall detector
`timescale 1ns/10ps
`include "stl_defs.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sdBit, irq, stalled = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] bridgeGatesA, bridgeGatesB, rd;
  stl_pkg::stl_sense_t sense;
  int err_count = 0;
  int samples_checked = 0;
  initial forever #20 mclk = ~mclk;
  stl_stall_detector uut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sdBit, .bridgeGatesA, .bridgeGatesB, .sense, .irq);
  stl_motor_model motor (.mclk, .gatesA(bridgeGatesA), .gatesB(bridgeGatesB), .sense,
    .stalled, .sdBit);
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int n = 0;
    logic done = 1'b0;
    s_axi_awaddr <= {24'h0, a, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 40) begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1'b1;
        rsp = s_axi_bresp;
      end
    end
    if (!done) begin
      err_count++;
      finish_test();
    end
  endtask
  // ready raised with the address and left high
  task automatic rdr(input logic [5:0] a);
    int n = 0;
    logic done = 1'b0;
    s_axi_araddr <= {24'h0, a, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 40) begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        done = 1'b1;
        rd = s_axi_rdata[7:0];
        rsp = s_axi_rresp;
      end
    end
    if (!done) begin
      err_count++;
      finish_test();
    end
  endtask
  task automatic t_map();
    for (int i = 0; i < 8; i++) begin
      rdr(i[5:0]);
      `CHK("reset value", 8'h00, rd)
    end
    rdr(6'h08);
    `CHK("read decerr", `STL_RESP_DECERR, rsp)
    wr(6'h08, 8'h5A);
    `CHK("write decerr", `STL_RESP_DECERR, rsp)
    wr(`STL_IDX_ACC_LO, 8'hA5);
    rdr(`STL_IDX_ACC_LO);
    `CHK("sum read only", 8'h00, rd)
    wr(`STL_IDX_RTZ_CTL, 8'h37);
    rdr(`STL_IDX_RTZ_CTL);
    `CHK("control readback", 8'h37, rd)
  endtask
  task automatic t_gates();
    logic [7:0] drv [4] = '{8'h09, 8'h90, 8'h06, 8'h60};
    wr(`STL_IDX_DET_CTL, 8'h80);
    for (int k = 0; k < 8; k++) begin
      wr(`STL_IDX_RTZ_CTL, {5'b11000, k[2:0]});
      tick(1);
      `CHK("gates A", k[2] ? 8'h00 : drv[k[1:0]], bridgeGatesA)
      `CHK("gates B", k[2] ? drv[k[1:0]] : 8'h00, bridgeGatesB)
      `CHK("sensed coil", {k[2], ~k[0]}, {sense.motorSelect, sense.senseSine})
    end
    wr(`STL_IDX_RTZ_CTL, 8'h21);
    tick(1);
    `CHK("recirculate", 8'h0A, bridgeGatesA)
    wr(`STL_IDX_RTZ_CTL, 8'h80);
    tick(1);
    `CHK("drive off", 8'h00, bridgeGatesA)
    wr(`STL_IDX_RTZ_CTL, 8'h40);
    wr(`STL_IDX_DET_CTL, 8'h00);
    tick(1);
    `CHK("disabled", 8'h00, bridgeGatesA)
  endtask
  task automatic t_modes();
    for (int k = 0; k < 4; k++) begin
      wr(`STL_IDX_RTZ_CTL, {k[1:0], 6'h00});
      rdr(`STL_IDX_DET_FLG);
      `CHK("mode", k[1:0], rd[5:4])
      `CHK("converter reset", ~k[1], sense.converterReset)
    end
  endtask
  task automatic t_integ();
    wr(`STL_IDX_DET_CTL, 8'h80);
    wr(`STL_IDX_RTZ_CTL, 8'hC0);
    tick(8);
    rdr(`STL_IDX_ACC_HI);
    `CHK("sum high", 8'h00, rd)
    rdr(`STL_IDX_ACC_LO);
    `CHK("above threshold", 1'b1, rd > 8'h08)
    wr(`STL_IDX_RTZ_CTL, 8'h40);
    rdr(`STL_IDX_ACC_LO);
    `CHK("sum cleared", 8'h00, rd)
    wr(`STL_IDX_RTZ_CTL, 8'hD0);
    tick(8);
    rdr(`STL_IDX_ACC_HI);
    `CHK("reversed sum", 8'hFF, rd)
    `CHK("polarity pin", 1'b1, sense.polarity)
    wr(`STL_IDX_RTZ_CTL, 8'h40);
    stalled <= 1'b1;
    wr(`STL_IDX_RTZ_CTL, 8'hC0);
    tick(8);
    rdr(`STL_IDX_ACC_HI);
    `CHK("below threshold", 1'b1, rd == 8'h00 || rd == 8'hFF)
    rdr(`STL_IDX_ACC_LO);
    `CHK("stalled sum", 1'b1, rd == 8'h00 || rd == 8'h01 || rd == 8'hFF)
    stalled <= 1'b0;
    wr(`STL_IDX_RTZ_CTL, 8'h00);
  endtask
  task automatic t_count();
    int n;
    int m;
    wr(`STL_IDX_DET_CTL, 8'h81);
    for (int p = 0; p < 4; p++) begin
      wr(`STL_IDX_CNT_CTL, 8'h00);
      wr(`STL_IDX_CNT_HI, 8'h00);
      wr(`STL_IDX_CNT_LO, 8'h02);
      rdr(`STL_IDX_DET_FLG);
      tick(1);
      `CHK("irq cleared", 1'b0, irq)
      wr(`STL_IDX_CNT_CTL, {6'h20, p[1:0]});
      m = 2 << (2 * p);
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
        @(posedge mclk);
        n++;
      end
      `CHK("zero time", 1'b1, (n + 4 >= m) && (n <= m + 3))
      if (n == 300) finish_test();
      rdr(`STL_IDX_DET_FLG);
      `CHK("zero flag", 1'b1, rd[0])
    end
    wr(`STL_IDX_DET_CTL, 8'h80);
    wr(`STL_IDX_CNT_CTL, 8'h80);
    rdr(`STL_IDX_DET_FLG);
    tick(10);
    `CHK("masked irq", 1'b0, irq)
    rdr(`STL_IDX_DET_FLG);
    `CHK("reload flag", 1'b1, rd[0])
    wr(`STL_IDX_CNT_CTL, 8'h00);
  endtask
  // a moving rotor drives the sum to its upper limit
  task automatic t_sat();
    int n = 0;
    wr(`STL_IDX_DET_CTL, 8'h82);
    wr(`STL_IDX_RTZ_CTL, 8'hC0);
    while (irq !== 1'b1 && n < 34000) begin
      @(posedge mclk);
      n++;
    end
    `CHK("saturate irq", 1'b1, irq)
    if (n == 34000) finish_test();
    rdr(`STL_IDX_ACC_HI);
    `CHK("saturated sum", 8'h7F, rd)
    rdr(`STL_IDX_DET_FLG);
    `CHK("saturate flag", 1'b1, rd[1])
    wr(`STL_IDX_RTZ_CTL, 8'h00);
    wr(`STL_IDX_DET_CTL, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_map();
    t_gates();
    t_modes();
    t_integ();
    t_count();
    t_sat();
    finish_test();
  end
endmodule
